// ===== logic/hfsg_top.sv
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none

module hfsg_top (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_port_bit_clock,
  input wire logic i_port_frame_sync,
  output logic o_port_frame_sync,
  output logic o_port_frame_sync_oe,
  output logic o_frame_start
);
  import hfsg_pkg::*;

  // ****************************************
  // Reset synchroniser (system clock)
  // ****************************************
  logic rst_meta_reg;
  logic rst_n_reg;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ****************************************
  // APB register file
  // ****************************************
  logic sel_reg;
  logic half_reg;
  logic [HFSG_FSD_W-1:0] fsd_reg;
  logic [HFSG_CNT_W-1:0] len_reg;
  logic [HFSG_CNT_W-1:0] wid_reg;
  logic cfg_err;
  logic [1:0] run_sync_reg;
  logic apb_wr;
  logic addr_ok;

  assign apb_wr = i_psel && i_penable && i_pwrite;
  assign addr_ok = (i_paddr == HFSG_ADDR_CTRL) ||
                   (i_paddr == HFSG_ADDR_FRAME_LEN) ||
                   (i_paddr == HFSG_ADDR_HIGH_WIDTH) ||
                   (i_paddr == HFSG_ADDR_STATUS);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_ok;

  // Frame length written whole in one word, all its bits at one address
  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sel_reg <= 1'b0;
      half_reg <= 1'b0;
      fsd_reg <= '0;
      len_reg <= HFSG_LEN_RST;
      wid_reg <= HFSG_WID_RST;
    end else if (apb_wr) begin
      unique case (i_paddr)
        HFSG_ADDR_CTRL: begin
          sel_reg <= i_pwdata[HFSG_CTRL_SEL_BIT];
          half_reg <= i_pwdata[HFSG_CTRL_HALF_BIT];
          fsd_reg <= i_pwdata[HFSG_CTRL_FSD_LSB +: HFSG_FSD_W];
        end
        HFSG_ADDR_FRAME_LEN: len_reg <= i_pwdata[HFSG_CNT_W-1:0];
        HFSG_ADDR_HIGH_WIDTH: wid_reg <= i_pwdata[HFSG_CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // Flags settings the generator cannot honour; the hardware still runs
  always_comb begin
    cfg_err = (len_reg < HFSG_LEN_MIN) || (len_reg > HFSG_LEN_MAX);
    if (sel_reg && len_reg[0]) cfg_err = 1'b1;
    if (wid_reg < HFSG_ONE || wid_reg >= len_reg) cfg_err = 1'b1;
    if (half_reg && wid_reg != (len_reg >> 1)) cfg_err = 1'b1;
  end

  always_comb begin
    o_prdata = '0;
    if (i_psel && !i_pwrite) begin
      unique case (i_paddr)
        HFSG_ADDR_CTRL: begin
          o_prdata[HFSG_CTRL_SEL_BIT] = sel_reg;
          o_prdata[HFSG_CTRL_HALF_BIT] = half_reg;
          o_prdata[HFSG_CTRL_FSD_LSB +: HFSG_FSD_W] = fsd_reg;
        end
        HFSG_ADDR_FRAME_LEN: o_prdata[HFSG_CNT_W-1:0] = len_reg;
        HFSG_ADDR_HIGH_WIDTH: o_prdata[HFSG_CNT_W-1:0] = wid_reg;
        HFSG_ADDR_STATUS: begin
          o_prdata[HFSG_STAT_RUN_BIT] = run_sync_reg[1];
          o_prdata[HFSG_STAT_ERR_BIT] = cfg_err;
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // Configuration crossing (handshake)
  // ****************************************
  // Settings move as one word on a toggle; the bit-clock side takes the
  // word only after the toggle is seen twice, so the bus is stable then.
  hfsg_cfg_t cfg_hold_reg;
  logic req_tog_reg;
  logic [1:0] ack_sync_reg;
  logic ack_tog_reg;
  logic [1:0] req_sync_reg;
  hfsg_cfg_t cfg_link_reg;
  logic bc_rst_meta_reg;
  logic bc_rst_n_reg;
  hfsg_cfg_t cfg_now;

  // Packed view of the live settings, compared with the word in flight
  assign cfg_now = '{sel: sel_reg, half: half_reg, fsd: fsd_reg,
                     len: len_reg, wid: wid_reg};

  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cfg_hold_reg <= '0;
      req_tog_reg <= 1'b0;
      ack_sync_reg <= '0;
    end else begin
      ack_sync_reg <= {ack_sync_reg[0], ack_tog_reg};
      if (ack_sync_reg[1] == req_tog_reg) begin
        cfg_hold_reg <= cfg_now;
        if (cfg_hold_reg != cfg_now) begin
          req_tog_reg <= ~req_tog_reg;
        end
      end
    end
  end

  // Bit clock may stop; reset for that side is released on its own edges
  always_ff @(posedge i_port_bit_clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      bc_rst_meta_reg <= 1'b0;
      bc_rst_n_reg <= 1'b0;
    end else begin
      bc_rst_meta_reg <= 1'b1;
      bc_rst_n_reg <= bc_rst_meta_reg;
    end
  end

  always_ff @(posedge i_port_bit_clock or negedge bc_rst_n_reg) begin
    if (!bc_rst_n_reg) begin
      req_sync_reg <= '0;
      ack_tog_reg <= 1'b0;
      cfg_link_reg <= '0;
    end else begin
      req_sync_reg <= {req_sync_reg[0], req_tog_reg};
      if (req_sync_reg[1] != ack_tog_reg) begin
        cfg_link_reg <= cfg_hold_reg;
        ack_tog_reg <= req_sync_reg[1];
      end
    end
  end

  // ****************************************
  // Frame generator (bit-clock domain)
  // ****************************************
  // The host owns the bit clock; it is only ever an input here.
  logic [HFSG_CNT_W-1:0] bit_cnt_reg;
  logic [HFSG_FSD_W:0] dly_cnt_reg;
  logic sync_reg;
  logic start_reg;
  logic running_reg;
  logic wrap;

  // Count 0..len-1; the final count wraps to zero and opens a frame
  assign wrap = (bit_cnt_reg >= cfg_link_reg.len - HFSG_ONE);

  always_ff @(posedge i_port_bit_clock or negedge bc_rst_n_reg) begin
    if (!bc_rst_n_reg) begin
      bit_cnt_reg <= '0;
      sync_reg <= 1'b0;
      running_reg <= 1'b0;
    end else if (!cfg_link_reg.sel) begin
      bit_cnt_reg <= '0;
      sync_reg <= 1'b0;
      running_reg <= 1'b0;
    end else begin
      running_reg <= 1'b1;
      bit_cnt_reg <= wrap ? '0 : bit_cnt_reg + HFSG_ONE;
      if (wrap) begin
        sync_reg <= 1'b1;
      end else if (bit_cnt_reg + HFSG_ONE >= cfg_link_reg.wid) begin
        sync_reg <= 1'b0;
      end
    end
  end

  // Frame data starts fsd bit clocks after the sync rising edge
  always_ff @(posedge i_port_bit_clock or negedge bc_rst_n_reg) begin
    if (!bc_rst_n_reg) begin
      dly_cnt_reg <= '0;
      start_reg <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      if (cfg_link_reg.sel && wrap) begin
        if (cfg_link_reg.fsd == '0) begin
          start_reg <= 1'b1;
        end else begin
          dly_cnt_reg <= {1'b0, cfg_link_reg.fsd};
        end
      end else if (dly_cnt_reg != '0) begin
        dly_cnt_reg <= dly_cnt_reg - 1'b1;
        start_reg <= (dly_cnt_reg == {{HFSG_FSD_W{1'b0}}, 1'b1});
      end
    end
  end

  // In pure slave mode the sync pin is an input; mark frames from it
  logic [2:0] ext_sync_reg;
  always_ff @(posedge i_port_bit_clock or negedge bc_rst_n_reg) begin
    if (!bc_rst_n_reg) begin
      ext_sync_reg <= '0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], i_port_frame_sync};
    end
  end

  assign o_port_frame_sync = sync_reg;
  assign o_port_frame_sync_oe = cfg_link_reg.sel;
  assign o_frame_start = cfg_link_reg.sel ? start_reg
                         : (ext_sync_reg[1] && !ext_sync_reg[2]);

  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      run_sync_reg <= '0;
    end else begin
      run_sync_reg <= {run_sync_reg[0], running_reg};
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_sync_rise_wrap: assert property (@(posedge i_port_bit_clock)
    disable iff (!bc_rst_n_reg)
    (cfg_link_reg.sel && wrap && $stable(cfg_link_reg)) |=> sync_reg)
    else $error("sync not high after wrap");
  a_sync_low_width: assert property (@(posedge i_port_bit_clock)
    disable iff (!bc_rst_n_reg)
    (cfg_link_reg.sel && !wrap && bit_cnt_reg >= cfg_link_reg.wid)
    |-> !sync_reg)
    else $error("sync high beyond width");
  a_cnt_bound: assert property (@(posedge i_port_bit_clock)
    disable iff (!bc_rst_n_reg)
    (cfg_link_reg.sel && $stable(cfg_link_reg) && $past(cfg_link_reg.sel))
    |-> bit_cnt_reg < cfg_link_reg.len)
    else $error("counter past frame length");
  a_slave_idle: assert property (@(posedge i_port_bit_clock)
    disable iff (!bc_rst_n_reg)
    !cfg_link_reg.sel |-> !o_port_frame_sync_oe ##1
      (cfg_link_reg.sel || !sync_reg))
    else $error("driving sync in slave mode");
  a_start_delay: assert property (@(posedge i_port_bit_clock)
    disable iff (!bc_rst_n_reg)
    (cfg_link_reg.sel && wrap && cfg_link_reg.fsd == 3'h3 &&
     $stable(cfg_link_reg))
    |-> ##1 !start_reg ##1 !start_reg ##1 !start_reg ##1 start_reg)
    else $error("frame start delay wrong");
  a_len_err: assert property (@(posedge i_clk)
    disable iff (!rst_n_reg)
    (len_reg > HFSG_LEN_MAX || len_reg < HFSG_LEN_MIN) |-> cfg_err)
    else $error("bad length not flagged");
  a_odd_err: assert property (@(posedge i_clk)
    disable iff (!rst_n_reg)
    (sel_reg && len_reg[0]) |-> cfg_err)
    else $error("odd length not flagged");
  a_half_err: assert property (@(posedge i_clk)
    disable iff (!rst_n_reg)
    (half_reg && wid_reg != (len_reg >> 1)) |-> cfg_err)
    else $error("half duty mismatch not flagged");
  a_wid_err: assert property (@(posedge i_clk)
    disable iff (!rst_n_reg)
    (wid_reg >= len_reg) |-> o_pslverr || cfg_err)
    else $error("wide pulse not flagged");
  a_derived_drive: assert property (@(posedge i_port_bit_clock)
    disable iff (!bc_rst_n_reg)
    cfg_link_reg.sel |-> o_port_frame_sync_oe)
    else $error("derived sync not driven");
  // Counter moves by exactly one bit clock per edge inside a frame
  a_cnt_step: assert property (@(posedge i_port_bit_clock)
    disable iff (!bc_rst_n_reg)
    (cfg_link_reg.sel && $past(cfg_link_reg.sel) && !$past(wrap) &&
     $stable(cfg_link_reg))
    |-> bit_cnt_reg == $past(bit_cnt_reg) + HFSG_ONE)
    else $error("counter skipped a bit clock");
  a_start_single: assert property (@(posedge i_port_bit_clock)
    disable iff (!bc_rst_n_reg)
    (cfg_link_reg.sel && start_reg) |=> !start_reg)
    else $error("frame start longer than one bit clock");
  a_slave_start: assert property (@(posedge i_port_bit_clock)
    disable iff (!bc_rst_n_reg)
    (!cfg_link_reg.sel && $rose(ext_sync_reg[1])) |-> o_frame_start)
    else $error("slave frame start missed");
  // The link side copies the held word a few edges late; it must not move
  a_hold_stable: assert property (@(posedge i_clk)
    disable iff (!rst_n_reg)
    (ack_sync_reg[1] != req_tog_reg) |=> $stable(cfg_hold_reg))
    else $error("settings word moved while in flight");

  // ****************************************
  // Cover points
  // ****************************************
  c_frame_wrap: cover property (@(posedge i_port_bit_clock)
    disable iff (!bc_rst_n_reg) cfg_link_reg.sel && wrap);
  c_delayed_start: cover property (@(posedge i_port_bit_clock)
    disable iff (!bc_rst_n_reg) cfg_link_reg.fsd != '0 && start_reg);
  c_half_duty: cover property (@(posedge i_port_bit_clock)
    disable iff (!bc_rst_n_reg) cfg_link_reg.half && wrap);
  c_slave_edge: cover property (@(posedge i_port_bit_clock)
    disable iff (!bc_rst_n_reg) !cfg_link_reg.sel && o_frame_start);
  c_cfg_cross: cover property (@(posedge i_port_bit_clock)
    disable iff (!bc_rst_n_reg) req_sync_reg[1] != ack_tog_reg);

endmodule : hfsg_top
`default_nettype wire

// ===== logic/hfsg_pkg.sv
`default_nettype none

package hfsg_pkg;

  // ****************************************
  // Register map (APB byte offsets)
  // ****************************************
  localparam logic [7:0] HFSG_ADDR_CTRL = 8'h00;
  localparam logic [7:0] HFSG_ADDR_FRAME_LEN = 8'h04;
  localparam logic [7:0] HFSG_ADDR_HIGH_WIDTH = 8'h08;
  localparam logic [7:0] HFSG_ADDR_STATUS = 8'h0c;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int HFSG_CNT_W = 13;
  localparam int HFSG_LOW_W = 8;
  localparam int HFSG_FSD_W = 3;
  localparam int HFSG_CTRL_SEL_BIT = 0;
  localparam int HFSG_CTRL_HALF_BIT = 1;
  localparam int HFSG_CTRL_FSD_LSB = 4;
  localparam int HFSG_STAT_RUN_BIT = 0;
  localparam int HFSG_STAT_ERR_BIT = 1;

  // ****************************************
  // Limits and reset values
  // ****************************************
  localparam logic [12:0] HFSG_LEN_MIN = 13'h0010;
  localparam logic [12:0] HFSG_LEN_MAX = 13'h1000;
  localparam logic [12:0] HFSG_LEN_RST = 13'h0040;
  localparam logic [12:0] HFSG_WID_RST = 13'h0020;
  localparam logic [12:0] HFSG_ONE = 13'h0001;

  typedef struct packed {
    logic sel;
    logic half;
    logic [2:0] fsd;
    logic [12:0] len;
    logic [12:0] wid;
  } hfsg_cfg_t;

endpackage : hfsg_pkg
`default_nettype wire

// ===== dv/hfsg_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module hfsg_host_model #(
  parameter int RATIO = 16
) (
  input wire logic i_sync_drive,
  output logic o_bit_clock,
  output logic o_frame_sync
);
  int cnt = 0;

  // Host owns the bit clock and runs it free; odd phase vs the bus clock
  initial begin
    o_bit_clock = 1'b0;
    #37.3;
    forever #62.5 o_bit_clock = ~o_bit_clock;
  end

  initial o_frame_sync = 1'b0;

  // Frame is an even whole number of bit clocks
  always @(negedge o_bit_clock) begin
    cnt <= (cnt + 1) % RATIO;
    if (i_sync_drive)
      o_frame_sync <= (cnt < RATIO / 2);
    else
      o_frame_sync <= ~o_frame_sync; // Released: keep moving, never frozen
  end
endmodule : hfsg_host_model
`default_nettype wire

// ===== dv/hfsg_top_test.sv
`timescale 1ns/100ps
`default_nettype none

module hfsg_top_test;
  import hfsg_pkg::*;
  typedef struct {
    logic [7:0] a;
    logic w;
    logic [31:0] d;
    logic [31:0] r;
    logic e;
  } hfsg_row_t;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, bclk, host_sync, sync_out, sync_oe, fstart, err;
  wire logic sync_wire = sync_oe ? sync_out : host_sync;
  int errors = 0;
  int checked = 0;
  int hi, per, dly, n;
  hfsg_row_t rows[8] = '{
    '{HFSG_ADDR_CTRL, 1'b0, 32'h0, 32'h0, 1'b0},
    '{HFSG_ADDR_FRAME_LEN, 1'b0, 32'h0, 32'h40, 1'b0},
    '{HFSG_ADDR_HIGH_WIDTH, 1'b0, 32'h0, 32'h20, 1'b0},
    '{HFSG_ADDR_FRAME_LEN, 1'b1, 32'h1000, 32'h0, 1'b0},
    '{HFSG_ADDR_FRAME_LEN, 1'b0, 32'h0, 32'h1000, 1'b0},
    '{HFSG_ADDR_CTRL, 1'b1, 32'hffff_fff2, 32'h0, 1'b0},
    '{HFSG_ADDR_CTRL, 1'b0, 32'h0, 32'h72, 1'b0},
    '{8'h10, 1'b0, 32'h0, 32'h0, 1'b1}};
  int cf[4][4] = '{'{16, 8, 0, 0}, '{16, 1, 7, 0}, '{18, 17, 0, 0},
                   '{24, 12, 3, 1}};

  always #12.5 clk = ~clk;

  hfsg_host_model host (.i_sync_drive(!sync_oe), .o_bit_clock(bclk),
    .o_frame_sync(host_sync));

  hfsg_top dut (.i_clk(clk), .i_resetn(resetn), .i_paddr(paddr),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_port_bit_clock(bclk),
    .i_port_frame_sync(sync_wire), .o_port_frame_sync(sync_out),
    .o_port_frame_sync_oe(sync_oe), .o_frame_start(fstart));

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Settings take a handshake to cross, so let two frames pass
  task cfg(input int len, input int wid, input logic [31:0] ctrl);
    apb(HFSG_ADDR_CTRL, 1'b1, 32'h0);
    apb(HFSG_ADDR_FRAME_LEN, 1'b1, 32'(len));
    apb(HFSG_ADDR_HIGH_WIDTH, 1'b1, 32'(wid));
    apb(HFSG_ADDR_CTRL, 1'b1, ctrl);
    repeat (2 * len + 24) @(posedge bclk);
  endtask : cfg

  // One frame from sync rise to the next, sampled on the bit clock
  task measure;
    logic p;
    do @(posedge bclk); while (sync_out !== 1'b0);
    do @(posedge bclk); while (sync_out !== 1'b1);
    hi = 0;
    per = 0;
    dly = -1;
    p = 1'b0;
    while (!(sync_out === 1'b1 && p === 1'b0) || per == 0) begin
      if (sync_out === 1'b1) hi++;
      if (fstart === 1'b1 && dly < 0) dly = per;
      p = sync_out;
      per++;
      @(posedge bclk);
    end
  endtask : measure

  task results;
    $display("Counts: %0d checks, %0d errors", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  initial begin
    // Whole run needs well under 200 us; this leaves a wide margin
    #1_000_000;
    errors++;
    $display("Error %0t: watchdog expired", $time);
    results();
  end

  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      chk(32'(err), 32'(rows[i].e), "slave error");
      if (!rows[i].w) chk(rd, rows[i].r, "read data");
    end
    $display("Test registers done");
    foreach (cf[i]) begin
      cfg(cf[i][0], cf[i][1], 32'(cf[i][2] << 4) | 32'(cf[i][3] << 1) | 1);
      chk(32'(sync_oe), 32'h1, "sync drive");
      measure();
      chk(32'(per), 32'(cf[i][0]), "frame length");
      chk(32'(hi), 32'(cf[i][1]), "high width");
      chk(32'(dly), 32'(cf[i][2]), "start delay");
      apb(HFSG_ADDR_STATUS, 1'b0, 32'h0);
      chk(32'(rd[0]), 32'h1, "running");
    end
    $display("Test derived frames done");
    cfg(16, 16, 32'h1);
    apb(HFSG_ADDR_STATUS, 1'b0, 32'h0);
    chk(32'(rd[1]), 32'h1, "width not flagged");
    $display("Test bad width done");
    cfg(16, 8, 32'h0);
    chk(32'(sync_oe), 32'h0, "slave drives sync");
    n = 0;
    repeat (64) begin
      @(posedge bclk);
      if (fstart === 1'b1) n++;
    end
    chk(32'(n), 32'h4, "slave frame starts");
    $display("Test slave done");
    cfg(16, 8, 32'h1);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'(sync_oe), 32'h0, "drive in reset");
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    apb(HFSG_ADDR_FRAME_LEN, 1'b0, 32'h0);
    chk(rd, 32'h40, "length after reset");
    $display("Test mid reset done");
    results();
  end
endmodule : hfsg_top_test
`default_nettype wire
